/* verilog/gauge_command_status.sv */
// serial command interpreter and status return of a dual gauge driver
// assumes the serial clock and pins are asynchronous and slow against clk_i;
// step and done pulses come from motion logic on clk_i
`timescale 1ns/100ps

// Overview of operation
// - enable/config word with null bit set only polls status, changes nothing
// - status bits 4 and 5 flag a microstep since last status return
// - zero-return command: bit 0 picks gauge, bit 1 starts or cancels
// - zero-return bits 3:2 pick accumulator byte shown on status 15:8
// - status bit 2 high while gauge 0 returns to zero
// - status bit 3 high while gauge 1 returns to zero
// - velocity command: bits 8,9 pick gauges, bits 7:0 table index
// - gauge 0 position command loads twelve-bit target
// - gauge 1 position command loads twelve-bit target
// - status bit 6 shows motor supply out of range
// - status bits 0 and 1 flag overtemperature of each gauge
// - reset pin low restores defaults except the interrupt registers and holds sleep
module gauge_command_status
  import gauge_cmd_pkg::*;
#(
  parameter int POS_W = 12,
  parameter int VEL_W = 8,
  parameter int ACC_W = 32
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic reset_pin_n_i,
  output logic sleep_o,
  input wire logic [1:0] microstep_i,
  input wire logic [1:0] zero_done_i,
  input wire logic [ACC_W-1:0] zero_accum_i,
  input wire logic [1:0] overtemp_i,
  input wire logic supply_bad_i,
  output logic [1:0] gauge_enable_o,
  output logic [ZR_CFG_W-1:0] zero_return_config_o,
  output logic [1:0] zero_start_o,
  output logic [1:0] zero_cancel_o,
  output logic [VEL_W-1:0] velocity_index0_o,
  output logic [VEL_W-1:0] velocity_index1_o,
  output logic [POS_W-1:0] target0_o,
  output logic [POS_W-1:0] target1_o,
  output logic [1:0] target_load_o,
  input wire logic [gauge_cmd_pkg::REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [gauge_cmd_pkg::REG_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [gauge_cmd_pkg::REG_DATA_W-1:0] reg_rdata_o,
  output logic irq_o
);

  import gauge_cmd_pkg::*;

  // ***************************************************************
  // parameter checks
  // ***************************************************************
  // field widths are fixed by the serial word layout
  if (POS_W != 12 || VEL_W != 8) begin : g_bad_width
    $error("gauge_command_status: POS_W must be 12 and VEL_W 8");
  end
  if (ACC_W != ACC_VIEWS * ACC_BYTE_W) begin : g_bad_acc
    $error("gauge_command_status: ACC_W must hold exactly four status bytes");
  end

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic sclk_q;
    logic cs_q;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [WORD_W-1:0] rx;
    logic [WORD_W-1:0] tx;
    logic miso;
    logic miso_oe;
    logic sleep;
    logic [1:0] gauge_en;
    logic [ZR_CFG_W-1:0] zr_cfg;
    logic [1:0] view_sel;
    logic [VEL_W-1:0] vel0;
    logic [VEL_W-1:0] vel1;
    logic [POS_W-1:0] tgt0;
    logic [POS_W-1:0] tgt1;
    logic [1:0] tgt_load;
    logic [1:0] zr_start;
    logic [1:0] zr_cancel;
    logic [1:0] busy;
    logic [1:0] moved;
    logic [1:0] ot_prev;
    logic supply_prev;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic irq;
    logic [REG_DATA_W-1:0] rdata;
  } state_t;

  localparam state_t STATE_RESET = '{cs_q: 1'b1, sleep: 1'b1, default: '0};

  state_t st;
  state_t next_st;

  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  logic [LINK_SYNC_W-1:0] link_s;
  logic [PIN_SYNC_W-1:0] pin_s;
  logic cs_s;
  logic sclk_s;
  logic mosi_s;
  logic pin_rst_n;
  logic supply_s;
  logic [1:0] ot_s;

  gauge_sync #(
    .WIDTH(LINK_SYNC_W),
    .RESET_VAL(LINK_SYNC_RESET)
  ) u_link_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .d_i({cs_n_i, sclk_i, mosi_i}),
    .q_o(link_s)
  );

  gauge_sync #(
    .WIDTH(PIN_SYNC_W),
    .RESET_VAL(PIN_SYNC_RESET)
  ) u_pin_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .d_i({reset_pin_n_i, supply_bad_i, overtemp_i}),
    .q_o(pin_s)
  );

  assign {cs_s, sclk_s, mosi_s} = link_s;
  assign {pin_rst_n, supply_s, ot_s} = pin_s;

  // ***************************************************************
  // link edges and status word
  // ***************************************************************
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic word_done;
  logic [ACC_BYTE_W-1:0] acc_byte;
  logic [WORD_W-1:0] status_word;
  logic [2:0] code;

  assign cs_fall = st.cs_q && !cs_s;
  assign cs_rise = !st.cs_q && cs_s;
  assign sclk_rise = !cs_s && !st.sclk_q && sclk_s;
  assign sclk_fall = !cs_s && st.sclk_q && !sclk_s;
  assign word_done = cs_rise && (st.bit_cnt == BIT_CNT_W'(WORD_W));
  assign code = st.rx[CODE_HI:CODE_LO];
  assign acc_byte = zero_accum_i[st.view_sel * ACC_BYTE_W +: ACC_BYTE_W];

  always_comb begin
    status_word = '0;
    status_word[ST_OVERTEMP0] = ot_s[0];
    status_word[ST_OVERTEMP1] = ot_s[1];
    status_word[ST_RETURN_BUSY0] = st.busy[0];
    status_word[ST_RETURN_BUSY1] = st.busy[1];
    status_word[ST_MOVED0] = st.moved[0];
    status_word[ST_MOVED1] = st.moved[1];
    status_word[ST_SUPPLY] = supply_s;
    status_word[ST_ACC_LO +: ACC_BYTE_W] = acc_byte;
  end

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    state_t held;
    logic [IRQ_W-1:0] events;
    logic [IRQ_W-1:0] clr;
    logic [1:0] moved_clr;
    logic [1:0] start;
    logic [1:0] cancel;
    held = st;
    events = '0;
    clr = '0;
    moved_clr = '0;
    start = '0;
    cancel = '0;
    next_st = st;
    next_st.cs_q = cs_s;
    next_st.sclk_q = sclk_s;
    next_st.tgt_load = '0;
    next_st.zr_start = '0;
    next_st.zr_cancel = '0;
    next_st.miso_oe = !cs_s;
    next_st.sleep = 1'b0;

    // status loads at frame start, shifts on falling clock
    if (cs_fall) begin
      next_st.tx = status_word;
      next_st.miso = status_word[WORD_W-1];
      next_st.bit_cnt = '0;
      moved_clr = 2'b11;
    end else if (sclk_fall) begin
      next_st.tx = {st.tx[WORD_W-2:0], 1'b0};
      next_st.miso = st.tx[WORD_W-2];
    end
    if (cs_s) begin
      next_st.miso = 1'b0;
    end
    // command sampled on rising clock, msb first
    if (sclk_rise) begin
      next_st.rx = {st.rx[WORD_W-2:0], mosi_s};
      if (st.bit_cnt != '1) begin
        next_st.bit_cnt = st.bit_cnt + BIT_CNT_W'(1);
      end
    end

    // a short or long frame is dropped whole
    if (word_done) begin
      events[IRQ_FRAME] = 1'b1;
      unique case (code)
        CMD_ENABLE_CONFIG: begin
          if (!st.rx[NULL_POLL_BIT]) begin
            next_st.gauge_en = {st.rx[ENABLE_G1_BIT], st.rx[ENABLE_G0_BIT]};
          end
        end
        CMD_VELOCITY: begin
          if (st.rx[VEL_G0_BIT]) begin
            next_st.vel0 = st.rx[VEL_W-1:0];
          end
          if (st.rx[VEL_G1_BIT]) begin
            next_st.vel1 = st.rx[VEL_W-1:0];
          end
        end
        CMD_GAUGE0_POS: begin
          next_st.tgt0 = st.rx[POS_W-1:0];
          next_st.tgt_load[0] = 1'b1;
        end
        CMD_GAUGE1_POS: begin
          next_st.tgt1 = st.rx[POS_W-1:0];
          next_st.tgt_load[1] = 1'b1;
        end
        CMD_ZERO_RETURN: begin
          // gauge select and start or cancel
          if (st.rx[ZR_START_CANCEL_BIT]) begin
            start[st.rx[ZR_GAUGE_SELECT_BIT]] = 1'b1;
          end else begin
            cancel[st.rx[ZR_GAUGE_SELECT_BIT]] = 1'b1;
          end
          next_st.view_sel = st.rx[ZR_VIEW_HI:ZR_VIEW_LO];
        end
        CMD_ZERO_RETURN_CONFIG: begin
          next_st.zr_cfg = st.rx[ZR_CFG_W-1:0];
        end
        default: begin
        end
      endcase
    end
    next_st.zr_start = start;
    next_st.zr_cancel = cancel;

    // busy until done or cancel; a fresh start wins
    next_st.busy = (st.busy & ~zero_done_i & ~cancel) | start;
    // a step in the clearing cycle is kept
    next_st.moved = (st.moved & ~moved_clr) | microstep_i;

    // ***************************************************************
    // interrupt registers
    // ***************************************************************
    next_st.ot_prev = ot_s;
    next_st.supply_prev = supply_s;
    events[IRQ_DONE0] = zero_done_i[0] && st.busy[0];
    events[IRQ_DONE1] = zero_done_i[1] && st.busy[1];
    events[IRQ_SUPPLY] = supply_s && !st.supply_prev;
    events[IRQ_OVERTEMP] = |(ot_s & ~st.ot_prev);
    if (reg_wr_i && reg_addr_i == REG_IRQ_ENABLE) begin
      next_st.irq_en = reg_wdata_i[IRQ_W-1:0];
    end
    if (reg_wr_i && reg_addr_i == REG_IRQ_CLEAR) begin
      clr = reg_wdata_i[IRQ_W-1:0];
    end
    // set wins over a clear in the same cycle
    next_st.irq_stat = (st.irq_stat & ~clr) | events;
    next_st.rdata = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_IRQ_STATUS: next_st.rdata = REG_DATA_W'(st.irq_stat);
        REG_IRQ_ENABLE: next_st.rdata = REG_DATA_W'(st.irq_en);
        default: next_st.rdata = '0;
      endcase
    end
    next_st.irq = |(next_st.irq_stat & next_st.irq_en);

    // reset pin restores defaults, interrupt block keeps running
    if (!pin_rst_n) begin
      held = next_st;
      next_st = STATE_RESET;
      next_st.irq_stat = held.irq_stat;
      next_st.irq_en = held.irq_en;
      next_st.irq = held.irq;
      next_st.rdata = held.rdata;
      next_st.supply_prev = held.supply_prev;
      next_st.ot_prev = held.ot_prev;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= STATE_RESET;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign miso_o = st.miso;
  assign miso_oe_o = st.miso_oe;
  assign sleep_o = st.sleep;
  assign gauge_enable_o = st.gauge_en;
  assign zero_return_config_o = st.zr_cfg;
  assign zero_start_o = st.zr_start;
  assign zero_cancel_o = st.zr_cancel;
  assign velocity_index0_o = st.vel0;
  assign velocity_index1_o = st.vel1;
  assign target0_o = st.tgt0;
  assign target1_o = st.tgt1;
  assign target_load_o = st.tgt_load;
  assign reg_rdata_o = st.rdata;
  assign irq_o = st.irq;

endmodule : gauge_command_status

/* verilog/gauge_cmd_pkg.sv */
// constants, command codes and status layout of the gauge command and status block
// assumes a 16-bit serial word, command code in the top three bits
package gauge_cmd_pkg;

  // ***************************************************************
  // serial word
  // ***************************************************************
  localparam int WORD_W = 16;
  localparam int BIT_CNT_W = 5;
  localparam int CODE_HI = 15;
  localparam int CODE_LO = 13;

  typedef enum logic [2:0] {
    CMD_ENABLE_CONFIG = 3'h0,
    CMD_VELOCITY = 3'h1,
    CMD_GAUGE0_POS = 3'h2,
    CMD_GAUGE1_POS = 3'h3,
    CMD_ZERO_RETURN = 3'h4,
    CMD_ZERO_RETURN_CONFIG = 3'h5
  } command_t;

  // ***************************************************************
  // command fields
  // ***************************************************************
  localparam int NULL_POLL_BIT = 12;
  localparam int ENABLE_G0_BIT = 0;
  localparam int ENABLE_G1_BIT = 1;
  localparam int ZR_CFG_W = 13;
  localparam int ZR_GAUGE_SELECT_BIT = 0;
  localparam int ZR_START_CANCEL_BIT = 1;
  localparam int ZR_VIEW_LO = 2;
  localparam int ZR_VIEW_HI = 3;
  localparam int VEL_G0_BIT = 8;
  localparam int VEL_G1_BIT = 9;

  // ***************************************************************
  // status word
  // ***************************************************************
  localparam int ST_OVERTEMP0 = 0;
  localparam int ST_OVERTEMP1 = 1;
  localparam int ST_RETURN_BUSY0 = 2;
  localparam int ST_RETURN_BUSY1 = 3;
  localparam int ST_MOVED0 = 4;
  localparam int ST_MOVED1 = 5;
  localparam int ST_SUPPLY = 6;
  localparam int ST_ACC_LO = 8;
  localparam int ACC_BYTE_W = 8;
  localparam int ACC_VIEWS = 4;

  // ***************************************************************
  // interrupt registers
  // ***************************************************************
  localparam int IRQ_W = 5;
  localparam int IRQ_FRAME = 0;
  localparam int IRQ_DONE0 = 1;
  localparam int IRQ_DONE1 = 2;
  localparam int IRQ_SUPPLY = 3;
  localparam int IRQ_OVERTEMP = 4;
  localparam int REG_ADDR_W = 2;
  localparam int REG_DATA_W = 8;
  localparam logic [REG_ADDR_W-1:0] REG_IRQ_STATUS = 2'h0;
  localparam logic [REG_ADDR_W-1:0] REG_IRQ_ENABLE = 2'h1;
  localparam logic [REG_ADDR_W-1:0] REG_IRQ_CLEAR = 2'h2;

  // ***************************************************************
  // synchroniser reset values
  // ***************************************************************
  // link order {cs_n, sclk, mosi}: chip select idles high
  localparam int LINK_SYNC_W = 3;
  localparam logic [LINK_SYNC_W-1:0] LINK_SYNC_RESET = 3'h4;
  // pin order {reset_pin_n, supply_bad, overtemp1, overtemp0}
  localparam int PIN_SYNC_W = 4;
  localparam logic [PIN_SYNC_W-1:0] PIN_SYNC_RESET = 4'h0;

endpackage : gauge_cmd_pkg

/* verilog/gauge_sync.sv */
// two flip-flop synchroniser for a group of independent levels
// assumes each bit is a slow level; bits are not coherent with each other
`timescale 1ns/100ps
module gauge_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.first = d_i;
    // first stage feeds only the second
    next_st.second = st.first;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '{first: RESET_VAL, second: RESET_VAL};
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign q_o = st.second;

endmodule : gauge_sync

/* test/gauge_cmd_sva.sv */
// concurrent checks on the ports of the gauge command and status block
// assumes one clock domain; bound to the block by the statement at the foot
`timescale 1ns/100ps
module gauge_cmd_sva
  import gauge_cmd_pkg::*;
#(
  parameter int POS_W = 12
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic cs_n_i,
  input wire logic reset_pin_n_i,
  input wire logic miso_o,
  input wire logic miso_oe_o,
  input wire logic sleep_o,
  input wire logic [1:0] gauge_enable_o,
  input wire logic [POS_W-1:0] target0_o,
  input wire logic [1:0] target_load_o,
  input wire logic [1:0] zero_start_o,
  input wire logic [1:0] zero_cancel_o,
  input wire logic reg_rd_i,
  input wire logic [gauge_cmd_pkg::REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [gauge_cmd_pkg::REG_DATA_W-1:0] reg_rdata_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // ***************************************************************
  // assertions
  // ***************************************************************
  sleep_on_pin_a: assert property ((!reset_pin_n_i && ce_i) [*3] |=> sleep_o)
    else $error("sleep not entered on reset pin");
  sleep_defaults_a: assert property (sleep_o [*2] |-> gauge_enable_o == 2'h0 && target0_o == '0)
    else $error("settings kept while asleep");
  link_idle_a: assert property ((cs_n_i && ce_i) [*4] |=> !miso_oe_o && !miso_o)
    else $error("status line driven while deselected");
  link_drive_a: assert property ((!cs_n_i && ce_i && !sleep_o) [*4] |=> miso_oe_o)
    else $error("status line not driven in frame");
  link_quiet_a: assert property ((cs_n_i && ce_i) [*6] |-> target_load_o == 2'h0 && zero_start_o == 2'h0)
    else $error("command acted on outside a frame end");
  zero_pulse_a: assert property (zero_start_o != 2'h0 |=> zero_start_o == 2'h0)
    else $error("zero start longer than one cycle");
  zero_excl_a: assert property ((zero_start_o & zero_cancel_o) == 2'h0)
    else $error("start and cancel together");
  load_pulse_a: assert property (target_load_o != 2'h0 |=> target_load_o == 2'h0)
    else $error("target load longer than one cycle");
  target_hold_a: assert property ($changed(target0_o) |-> target_load_o[0] || sleep_o)
    else $error("target changed without load");
  read_idle_a: assert property (ce_i && !(reg_rd_i && reg_addr_i <= 2'h1) |=> reg_rdata_o == 8'h00)
    else $error("read data not zero");
  read_top_a: assert property (reg_rdata_o[7:5] == 3'h0)
    else $error("unused read bits set");
  // ***************************************************************
  // covers
  // ***************************************************************
  start_c: cover property (zero_start_o != 2'h0);
  load_c: cover property (target_load_o != 2'h0);
  irq_c: cover property ($rose(irq_o));
endmodule : gauge_cmd_sva

bind gauge_command_status gauge_cmd_sva #(.POS_W(POS_W)) gauge_cmd_sva_inst (
  .clk_i, .arst_n_i, .ce_i, .cs_n_i, .reset_pin_n_i, .miso_o, .miso_oe_o, .sleep_o,
  .gauge_enable_o, .target0_o, .target_load_o, .zero_start_o, .zero_cancel_o,
  .reg_rd_i, .reg_addr_i, .reg_rdata_o, .irq_o
);

/* test/spi_host_model.sv */
// host side of the serial command link: mode 0, msb first, 64 ns period
// assumes the device samples its pins with a much faster clock
`timescale 1ns/100ps
module spi_host_model (
  output logic cs_n_o,
  output logic sclk_o,
  output logic mosi_o,
  input wire logic miso_i
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end

  task automatic xfer(input logic [15:0] cmd, output logic [15:0] st);
    #3 cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_o = cmd[i];
      #32 sclk_o = 1'b1;
      // sample late: status bit moves up to three cycles after a fall
      #31 st[i] = miso_i;
      #1 sclk_o = 1'b0;
    end
    #32 cs_n_o = 1'b1;
    // released data line must not show a stale bit
    mosi_o = ~mosi_o;
    #100;
  endtask : xfer
endmodule : spi_host_model

/* test/tb_top.sv */
// bench of the gauge command block against a behavioural model
// assumes the host model and the bound checker are compiled before it
`timescale 1ns/100ps
module tb_top;
  import gauge_cmd_pkg::*;
  logic clk_i = 1'b0, arst_n_i = 1'b0, reset_pin_n_i = 1'b1, supply_bad_i = 1'b0;
  logic cs_n_i, sclk_i, mosi_i, miso_o, miso_oe_o, sleep_o, irq_o;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, ce_i = 1'b1;
  logic [5:0] last_pulse = '0;
  logic [1:0] microstep_i = '0, zero_done_i = '0, overtemp_i = '0, reg_addr_i = '0;
  logic [1:0] gauge_enable_o, zero_start_o, zero_cancel_o, target_load_o;
  logic [31:0] zero_accum_i = '0;
  logic [12:0] zero_return_config_o;
  logic [7:0] velocity_index0_o, velocity_index1_o, reg_rdata_o, reg_wdata_i = '0;
  logic [11:0] target0_o, target1_o;
  integer seed = 32'h9ff61d3b, num_errors = 0, checks = 0, cycles = 0;
  logic [1:0] m_en, m_busy, m_mv, m_ot = '0, ms;
  logic [7:0] m_v0, m_v1;
  logic [11:0] m_t0, m_t1;
  logic [12:0] m_cfg;
  logic [15:0] st;
  int m_view, pulse_cnt = 0;

  gauge_command_status gauge_command_status_inst (
    .clk_i, .arst_n_i, .ce_i, .cs_n_i, .sclk_i, .mosi_i, .miso_o, .miso_oe_o,
    .reset_pin_n_i, .sleep_o, .microstep_i, .zero_done_i, .zero_accum_i, .overtemp_i,
    .supply_bad_i, .gauge_enable_o, .zero_return_config_o, .zero_start_o, .zero_cancel_o,
    .velocity_index0_o, .velocity_index1_o, .target0_o, .target1_o, .target_load_o,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o
  );
  spi_host_model spi_host_model_inst (
    // undriven status line reads inverted, so a late enable corrupts the word
    .cs_n_o(cs_n_i), .sclk_o(sclk_i), .mosi_o(mosi_i), .miso_i(miso_oe_o ? miso_o : ~miso_o)
  );

  always #4 clk_i = ~clk_i;
  // log of one-cycle command pulses {start, cancel, load}
  always @(posedge clk_i) begin
    if ({zero_start_o, zero_cancel_o, target_load_o} != 6'h00) begin
      last_pulse <= {zero_start_o, zero_cancel_o, target_load_o};
      pulse_cnt <= pulse_cnt + 1;
    end
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic model_reset();
    {m_en, m_busy, m_mv, m_v0, m_v1, m_t0, m_t1, m_cfg} = '0;
    m_view = 0;
  endtask : model_reset

  task automatic reg_io(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1;
  endtask : reg_io

  // one frame: status of the frame, then the settings the word leaves behind
  task automatic send(input logic [15:0] w);
    int pc;
    logic [5:0] ep;
    pc = pulse_cnt;
    ep = '0;
    spi_host_model_inst.xfer(w, st);
    check(st, {zero_accum_i[m_view*8 +: 8], 1'b0, supply_bad_i,
               m_mv, m_busy, m_ot});
    m_mv = '0;
    case (w[15:13])
      3'h0: if (!w[12]) m_en = w[1:0];
      3'h1: begin
        if (w[8]) m_v0 = w[7:0];
        if (w[9]) m_v1 = w[7:0];
      end
      3'h2: begin
        m_t0 = w[11:0];
        ep[0] = 1'b1;
      end
      3'h3: begin
        m_t1 = w[11:0];
        ep[1] = 1'b1;
      end
      3'h4: begin
        m_view = w[3:2];
        m_busy[w[0]] = w[1];
        ep[w[1] ? 4 + w[0] : 2 + w[0]] = 1'b1;
      end
      3'h5: m_cfg = w[12:0];
      default: ;
    endcase
    check({gauge_enable_o, zero_return_config_o, velocity_index0_o, velocity_index1_o,
           target0_o, target1_o}, {m_en, m_cfg, m_v0, m_v1, m_t0, m_t1});
    check(pulse_cnt - pc, int'(ep != 6'h00));
    check((ep != 6'h00) ? last_pulse : 6'h00, ep);
  endtask : send

  initial begin
    model_reset();
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    check(sleep_o, 1'b0);
    reg_io(1'b0, 2'h3, 8'h00);
    check(reg_rdata_o, 8'h00);
    reg_io(1'b1, 2'h1, 8'h08);
    reg_io(1'b0, 2'h1, 8'h00);
    check(reg_rdata_o, 8'h08);
    send(16'h0003);
    send({14'h0400, 2'($random(seed))});
    for (int s = 1; s < 4; s++) send({6'h08, 2'(s), 8'($random(seed))});
    // unused command code must change nothing
    send(16'hE0FF);
    send({4'h4, 12'($random(seed))});
    send({4'h6, 12'($random(seed))});
    ms = 2'($random(seed));
    @(posedge clk_i);
    microstep_i <= ms;
    @(posedge clk_i);
    microstep_i <= 2'h0;
    m_mv = ms;
    send(16'h1000);
    send(16'h1000);
    for (int g = 0; g < 2; g++) begin
      send({3'h5, 13'($random(seed))});
      send({(g ? 4'h6 : 4'h4), 12'h018});
      @(posedge clk_i);
      zero_accum_i <= $random(seed);
      send({3'h4, 9'h000, 2'($random(seed)), 1'b1, 1'(g)});
      send(16'h1000);
      if (g == 0) begin
        @(posedge clk_i);
        zero_done_i <= 2'h1;
        @(posedge clk_i);
        zero_done_i <= 2'h0;
        m_busy[0] = 1'b0;
      end else begin
        send(16'h8001);
      end
      send(16'h1000);
    end
    @(posedge clk_i);
    overtemp_i <= 2'h1;
    supply_bad_i <= 1'b1;
    m_ot = 2'h1;
    repeat (6) @(posedge clk_i);
    #1 check(irq_o, 1'b1);
    reg_io(1'b0, 2'h0, 8'h00);
    check(reg_rdata_o, 8'h1B);
    reg_io(1'b1, 2'h2, 8'h08);
    check(irq_o, 1'b0);
    // write while frozen must be lost
    @(posedge clk_i);
    ce_i <= 1'b0;
    reg_io(1'b1, 2'h1, 8'h1F);
    @(posedge clk_i);
    ce_i <= 1'b1;
    reg_io(1'b0, 2'h1, 8'h00);
    check(reg_rdata_o, 8'h08);
    send(16'h1000);
    send(16'h0003);
    @(posedge clk_i);
    reset_pin_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1 check({sleep_o, gauge_enable_o, target0_o}, {1'b1, 2'h0, 12'h000});
    model_reset();
    @(posedge clk_i);
    reset_pin_n_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    send(16'h1000);
    give_verdict();
  end
endmodule : tb_top
